// ---- design/sdsm_pkg.sv ----
// constants and carrier types for the servo drive status monitor bank
package sdsm_pkg;
  // ---------------------------------------------------------------
  // register offsets (byte addresses, one word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] SDSM_OFF_CTRL      = 8'h00;
  localparam logic [7:0] SDSM_OFF_STATUS    = 8'h04;
  localparam logic [7:0] SDSM_OFF_IRQ_STAT  = 8'h08;
  localparam logic [7:0] SDSM_OFF_IRQ_CLR   = 8'h0c;
  localparam logic [7:0] SDSM_OFF_IRQ_EN    = 8'h10;
  localparam logic [7:0] SDSM_OFF_TEMP      = 8'h14;
  localparam logic [7:0] SDSM_OFF_CURRENT   = 8'h18;
  localparam logic [7:0] SDSM_OFF_IDENT     = 8'h1c;
  localparam logic [7:0] SDSM_OFF_ANGLE     = 8'h20;
  localparam logic [7:0] SDSM_OFF_TURNS     = 8'h24;
  localparam logic [7:0] SDSM_OFF_SPEED     = 8'h28;
  localparam logic [7:0] SDSM_OFF_FILT_SPD  = 8'h2c;
  localparam logic [7:0] SDSM_OFF_SWITCHES  = 8'h30;
  localparam logic [7:0] SDSM_OFF_LW_VER    = 8'h34;

  // ---------------------------------------------------------------
  // reset values, field positions, thresholds
  // ---------------------------------------------------------------
  localparam logic       SDSM_SPE_RESET     = 1'b1;
  localparam int         SDSM_CTRL_SPE_BIT  = 0;
  localparam int         SDSM_IRQ_OT_BIT    = 0;
  localparam int         SDSM_IRQ_PWM_BIT   = 1;
  localparam int         SDSM_IRQ_FB_BIT    = 2;
  localparam int         SDSM_IRQ_CFG_BIT   = 3;
  // current thresholds in 1/100 of peak current: 0.53 and 0.32
  localparam logic [7:0] SDSM_I_HI_PCT      = 8'd53;
  localparam logic [7:0] SDSM_I_LO_PCT      = 8'd32;
  // commutation frequency in units of 0.01 Hz: 2.9 Hz and 4.77 Hz
  localparam logic [15:0] SDSM_F_LO_CHZ     = 16'd290;
  localparam logic [15:0] SDSM_F_HI_CHZ     = 16'd477;
  localparam logic [2:0] SDSM_FB_SENSOR_ERR = 3'b001;
  localparam logic [2:0] SDSM_FB_MTURN_ERR  = 3'b011;
  localparam logic [4:0] SDSM_MODEL_MAX     = 5'd6;
  localparam logic [3:0] SDSM_ROTARY_MAX    = 4'd9;
  // arbitrary identity values
  localparam logic [3:0]  SDSM_HW_REV       = 4'h1;
  localparam logic [23:0] SDSM_LW_VER       = 24'h030001;
  // filtered velocity period: 26.21 ms at 200 MHz
  localparam int SDSM_CLK_MHZ        = 200;
  localparam int SDSM_FILT_PERIOD_US = 26210;
  localparam int SDSM_FILT_CYCLES    = SDSM_FILT_PERIOD_US * SDSM_CLK_MHZ;
  localparam int SDSM_FILT_SHIFT     = 9;  // 512 samples

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } sdsm_bus_req_t;

  typedef struct packed {
    logic [15:0] angle;      // 16.8 truncated to integral + frac kept in low byte
    logic [23:0] angle_raw;
    logic [11:0] turns;
    logic [15:0] speed;
    logic [2:0]  fb_fault;
  } sdsm_feedback_t;
endpackage : sdsm_pkg

// ---- design/sdsm_monitor.sv ----
// status and monitor register bank of the servo drive
// Notes on behaviour
// - go to half pwm when current above 0.53 peak and commutation below 2.9 Hz.
// - leave half pwm when current below 0.32 peak or commutation above 4.77 Hz.
// - halving flag reads 0 at base frequency and 1 at half frequency.
// - motor power only when hardware enable and serial power enable both active.
// - serial power enable comes up active so hardware enable alone decides.
// - writing 0 disables drive, writing 1 defers to hardware; 1 is default.
// - hardware revision is a 4-bit value that wraps after sixteen.
// - model code 0 to 31; codes outside defined set flag configuration error.
// - shaft angle sampled at 24 bits, shown as 65536 counts plus eight fraction bits.
// - multi-turn count is a signed sample from -2048 to +2047.
// - raw speed sample reported as is, 0.5588 rpm per count.
// - filtered speed is difference of angle samples 26.21 ms apart.
// - feedback fault code 001 sensor error, 011 multi-turn, others no fault.
// - dip switch read 0 to 15, position one lsb, open reads high.
// - rotary switch read 0 to 9.
// - over-temperature fault when heatsink temp reaches trip temp; both readable.
// - logicware version reported as three bytes.
// - flag shows six-step or sinusoidal commutation.
module sdsm_monitor
  import sdsm_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire sdsm_pkg::sdsm_bus_req_t bus_req,
  output logic [31:0]               rdata,
  output logic                      irq,
  input  wire logic                 hw_enable_pin,
  output logic                      motor_power_enable,
  output logic                      pwm_halving_flag,
  output logic                      heatsink_over_temp,
  output logic                      config_error,
  input  wire logic [7:0]           motor_current_pct,
  input  wire logic [15:0]          commutation_freq_chz,
  input  wire logic [15:0]          torque_current,
  input  wire logic [15:0]          nontorque_current,
  input  wire logic [11:0]          heatsink_temp,
  input  wire logic [11:0]          heatsink_trip_temp,
  input  wire logic [4:0]           model_code,
  input  wire sdsm_pkg::sdsm_feedback_t feedback,
  input  wire logic [3:0]           dip_switch_pins,
  input  wire logic [3:0]           rotary_switch_pins,
  input  wire logic                 trapezoidal_commutation_flag
);
  import sdsm_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0]  dip_s1;
    logic [3:0]  dip_s2;
    logic [3:0]  rot_s1;
    logic [3:0]  rot_s2;
    logic        hwen_s1;
    logic        hwen_s2;
    logic        serial_power_enable;
    logic        halving;
    logic        over_temp;
    logic        cfg_err;
    logic [3:0]  irq_stat;
    logic [3:0]  irq_en;
    logic        fb_fault_q;
    logic [31:0] filt_cnt;
    logic [23:0] angle_prev;
    logic [23:0] filt_speed;
    logic [31:0] rdata;
    logic        irq;
    logic        power;
  } sdsm_state_t;

  sdsm_state_t st;
  sdsm_state_t next_st;

  logic [23:0] angle_diff;
  logic        fb_fault;
  logic [31:0] read_mux;
  logic [3:0]  irq_events;

  always_comb begin
    next_st = st;
    angle_diff = 24'h000000;
    fb_fault = 1'b0;
    read_mux = 32'h0000_0000;
    irq_events = 4'h0;

    // pins from outside pass two flip-flops
    next_st.dip_s1 = dip_switch_pins;
    next_st.dip_s2 = st.dip_s1;
    next_st.rot_s1 = rotary_switch_pins;
    next_st.rot_s2 = st.rot_s1;
    next_st.hwen_s1 = hw_enable_pin;
    next_st.hwen_s2 = st.hwen_s1;

    // pwm halving hysteresis
    if (!st.halving) begin
      if ((motor_current_pct > SDSM_I_HI_PCT) && (commutation_freq_chz < SDSM_F_LO_CHZ)) begin
        next_st.halving = 1'b1;
      end
    end else begin
      if ((motor_current_pct < SDSM_I_LO_PCT) || (commutation_freq_chz > SDSM_F_HI_CHZ)) begin
        next_st.halving = 1'b0;
      end
    end

    next_st.over_temp = (heatsink_temp >= heatsink_trip_temp);
    next_st.cfg_err = (model_code > SDSM_MODEL_MAX);
    next_st.power = st.hwen_s2 && st.serial_power_enable;

    // feedback fault decode
    fb_fault = (feedback.fb_fault == SDSM_FB_SENSOR_ERR) ||
               (feedback.fb_fault == SDSM_FB_MTURN_ERR);
    next_st.fb_fault_q = fb_fault;

    // filtered speed: angle difference per period equals mean of 512 raw samples
    if (st.filt_cnt >= SDSM_FILT_CYCLES - 1) begin
      next_st.filt_cnt = 32'h0000_0000;
      angle_diff = feedback.angle_raw - st.angle_prev;
      next_st.filt_speed = angle_diff;
      next_st.angle_prev = feedback.angle_raw;
    end else begin
      next_st.filt_cnt = st.filt_cnt + 32'h0000_0001;
    end

    // interrupt events; set wins over clear
    irq_events[SDSM_IRQ_OT_BIT]  = next_st.over_temp && !st.over_temp;
    irq_events[SDSM_IRQ_PWM_BIT] = next_st.halving != st.halving;
    irq_events[SDSM_IRQ_FB_BIT]  = fb_fault && !st.fb_fault_q;
    irq_events[SDSM_IRQ_CFG_BIT] = next_st.cfg_err && !st.cfg_err;
    if (bus_req.wr && bus_req.addr == SDSM_OFF_IRQ_CLR) begin
      next_st.irq_stat = st.irq_stat & ~bus_req.wdata[3:0];
    end
    next_st.irq_stat = next_st.irq_stat | irq_events;

    if (bus_req.wr) begin
      unique case (bus_req.addr)
        SDSM_OFF_CTRL: begin
          next_st.serial_power_enable = bus_req.wdata[SDSM_CTRL_SPE_BIT];
        end
        SDSM_OFF_IRQ_EN: begin
          next_st.irq_en = bus_req.wdata[3:0];
        end
        default: begin
        end
      endcase
    end
    next_st.irq = |(next_st.irq_stat & next_st.irq_en);

    // reads have no side effects, unmapped reads return zero
    unique case (bus_req.addr)
      SDSM_OFF_CTRL:     read_mux = {31'h0, st.serial_power_enable};
      SDSM_OFF_STATUS:   read_mux = {26'h0, trapezoidal_commutation_flag, st.cfg_err,
                                     st.over_temp, st.power, st.hwen_s2,
                                     st.halving};
      SDSM_OFF_IRQ_STAT: read_mux = {28'h0, st.irq_stat};
      SDSM_OFF_IRQ_EN:   read_mux = {28'h0, st.irq_en};
      SDSM_OFF_TEMP:     read_mux = {4'h0, heatsink_trip_temp, 4'h0, heatsink_temp};
      SDSM_OFF_CURRENT:  read_mux = {torque_current, nontorque_current};
      SDSM_OFF_IDENT:    read_mux = {23'h0, model_code, SDSM_HW_REV};
      SDSM_OFF_ANGLE:    read_mux = {8'h0, feedback.angle_raw};
      SDSM_OFF_TURNS:    read_mux = {{20{feedback.turns[11]}}, feedback.turns};
      SDSM_OFF_SPEED:    read_mux = {{16{feedback.speed[15]}}, feedback.speed};
      SDSM_OFF_FILT_SPD: read_mux = {{8{st.filt_speed[23]}}, st.filt_speed};
      SDSM_OFF_SWITCHES: read_mux = {21'h0, feedback.fb_fault, st.rot_s2,
                                     st.dip_s2};
      SDSM_OFF_LW_VER:   read_mux = {8'h0, SDSM_LW_VER};
      default:           read_mux = 32'h0000_0000;
    endcase
    next_st.rdata = bus_req.rd ? read_mux : 32'h0000_0000;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
      st.serial_power_enable <= SDSM_SPE_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign rdata              = st.rdata;
  assign irq                = st.irq;
  assign motor_power_enable = st.power;
  assign pwm_halving_flag   = st.halving;
  assign heatsink_over_temp = st.over_temp;
  assign config_error       = st.cfg_err;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_halving_enter: assert property (@(posedge clk) disable iff (!reset_n)
    (!st.halving && motor_current_pct > SDSM_I_HI_PCT && commutation_freq_chz < SDSM_F_LO_CHZ)
    |=> st.halving) else $error("halving not entered");
  chk_halving_leave: assert property (@(posedge clk) disable iff (!reset_n)
    (st.halving && motor_current_pct < SDSM_I_LO_PCT) |=> !st.halving)
    else $error("halving not left");
  chk_halving_hold: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(pwm_halving_flag) |-> $past(motor_current_pct) > SDSM_I_HI_PCT)
    else $error("halving flag set without cause");
  chk_power_gate: assert property (@(posedge clk) disable iff (!reset_n)
    motor_power_enable |-> $past(st.hwen_s2) && $past(st.serial_power_enable))
    else $error("power without both enables");
  chk_spe_write: assert property (@(posedge clk) disable iff (!reset_n)
    (bus_req.wr && bus_req.addr == SDSM_OFF_CTRL && !bus_req.wdata[0]) |=> ##1 !motor_power_enable)
    else $error("disable write ignored");
  chk_over_temp: assert property (@(posedge clk) disable iff (!reset_n)
    (heatsink_temp >= heatsink_trip_temp) |=> heatsink_over_temp)
    else $error("over temperature missed");
  chk_cfg_err: assert property (@(posedge clk) disable iff (!reset_n)
    (model_code > SDSM_MODEL_MAX) |=> config_error) else $error("model error missed");
  chk_read_clean: assert property (@(posedge clk) disable iff (!reset_n)
    (bus_req.rd && !bus_req.wr) |=> st.irq_en == $past(st.irq_en))
    else $error("read changed state");

  // ---------------------------------------------------------------
  // power gating checks
  // ---------------------------------------------------------------
  // both enables are looked at through their registered copies, so the gate
  // lags the write by one cycle on top of the synchroniser delay
  chk_power_sw_off: assert property (@(posedge clk) disable iff (!reset_n)
    !st.serial_power_enable |=> !motor_power_enable)
    else $error("power while serial enable off");
  chk_power_hw_off: assert property (@(posedge clk) disable iff (!reset_n)
    !st.hwen_s2 |=> !motor_power_enable)
    else $error("power while hardware enable off");
  chk_power_on: assert property (@(posedge clk) disable iff (!reset_n)
    (st.hwen_s2 && st.serial_power_enable) |=> motor_power_enable)
    else $error("power withheld with both enables");
  chk_spe_set: assert property (@(posedge clk) disable iff (!reset_n)
    (bus_req.wr && bus_req.addr == SDSM_OFF_CTRL && bus_req.wdata[0])
    |=> st.serial_power_enable)
    else $error("serial enable write ignored");

  // ---------------------------------------------------------------
  // pwm hysteresis checks
  // ---------------------------------------------------------------
  chk_halving_fast: assert property (@(posedge clk) disable iff (!reset_n)
    (st.halving && commutation_freq_chz > SDSM_F_HI_CHZ) |=> !st.halving)
    else $error("halving kept at high speed");
  chk_halving_idle: assert property (@(posedge clk) disable iff (!reset_n)
    (!st.halving && !(motor_current_pct > SDSM_I_HI_PCT &&
      commutation_freq_chz < SDSM_F_LO_CHZ)) |=> !st.halving)
    else $error("halving entered without cause");
  // inside the band the flag must not chatter
  chk_halving_band: assert property (@(posedge clk) disable iff (!reset_n)
    (st.halving && motor_current_pct >= SDSM_I_LO_PCT &&
      commutation_freq_chz <= SDSM_F_HI_CHZ) |=> st.halving)
    else $error("halving left inside band");

  // ---------------------------------------------------------------
  // fault and interrupt checks
  // ---------------------------------------------------------------
  chk_temp_clear: assert property (@(posedge clk) disable iff (!reset_n)
    (heatsink_temp < heatsink_trip_temp) |=> !heatsink_over_temp)
    else $error("over temperature without cause");
  chk_cfg_ok: assert property (@(posedge clk) disable iff (!reset_n)
    (model_code <= SDSM_MODEL_MAX) |=> !config_error)
    else $error("model error without cause");
  chk_fb_fault_irq: assert property (@(posedge clk) disable iff (!reset_n)
    (feedback.fb_fault == SDSM_FB_MTURN_ERR && !st.fb_fault_q)
    |=> st.irq_stat[SDSM_IRQ_FB_BIT])
    else $error("multi-turn fault not flagged");
  chk_fb_no_fault: assert property (@(posedge clk) disable iff (!reset_n)
    (feedback.fb_fault != SDSM_FB_SENSOR_ERR && feedback.fb_fault != SDSM_FB_MTURN_ERR)
    |=> !st.fb_fault_q)
    else $error("fault seen on a no-fault code");
  chk_irq_level: assert property (@(posedge clk) disable iff (!reset_n)
    irq == |(st.irq_stat & st.irq_en))
    else $error("irq level disagrees with status");
  // a clear in the same cycle as a new event must not lose the event
  chk_set_wins: assert property (@(posedge clk) disable iff (!reset_n)
    (bus_req.wr && bus_req.addr == SDSM_OFF_IRQ_CLR && irq_events[SDSM_IRQ_OT_BIT])
    |=> st.irq_stat[SDSM_IRQ_OT_BIT])
    else $error("clear beat a new event");
  chk_filt_range: assert property (@(posedge clk) disable iff (!reset_n)
    st.filt_cnt < SDSM_FILT_CYCLES)
    else $error("filter period counter overran");

  // ---------------------------------------------------------------
  // read-back checks
  // ---------------------------------------------------------------
  chk_read_idle: assert property (@(posedge clk) disable iff (!reset_n)
    !bus_req.rd |=> rdata == 32'h0000_0000)
    else $error("read data without a read");
  chk_read_angle: assert property (@(posedge clk) disable iff (!reset_n)
    (bus_req.rd && bus_req.addr == SDSM_OFF_ANGLE)
    |=> rdata == {8'h00, $past(feedback.angle_raw)})
    else $error("angle read wrong");
  chk_read_turns: assert property (@(posedge clk) disable iff (!reset_n)
    (bus_req.rd && bus_req.addr == SDSM_OFF_TURNS)
    |=> rdata[11:0] == $past(feedback.turns) && rdata[31:12] == {20{rdata[11]}})
    else $error("turns read wrong");
  chk_read_speed: assert property (@(posedge clk) disable iff (!reset_n)
    (bus_req.rd && bus_req.addr == SDSM_OFF_SPEED)
    |=> rdata[15:0] == $past(feedback.speed) && rdata[31:16] == {16{rdata[15]}})
    else $error("speed read wrong");
  chk_read_rev: assert property (@(posedge clk) disable iff (!reset_n)
    (bus_req.rd && bus_req.addr == SDSM_OFF_IDENT) |=> rdata[3:0] == SDSM_HW_REV)
    else $error("revision read wrong");
  chk_read_halving: assert property (@(posedge clk) disable iff (!reset_n)
    (bus_req.rd && bus_req.addr == SDSM_OFF_STATUS) |=> rdata[0] == $past(st.halving))
    else $error("halving flag read wrong");
  chk_read_mode: assert property (@(posedge clk) disable iff (!reset_n)
    (bus_req.rd && bus_req.addr == SDSM_OFF_STATUS)
    |=> rdata[5] == $past(trapezoidal_commutation_flag))
    else $error("commutation mode read wrong");
  chk_read_switch: assert property (@(posedge clk) disable iff (!reset_n)
    (bus_req.rd && bus_req.addr == SDSM_OFF_SWITCHES)
    |=> rdata[7:0] == {$past(st.rot_s2), $past(st.dip_s2)})
    else $error("switch read wrong");
  chk_read_lw: assert property (@(posedge clk) disable iff (!reset_n)
    (bus_req.rd && bus_req.addr == SDSM_OFF_LW_VER) |=> rdata == {8'h00, SDSM_LW_VER})
    else $error("logicware read wrong");
endmodule : sdsm_monitor

// ---- tb/sdsm_host.sv ----
// host controller model that drives the register port of the monitor bank
module sdsm_host
  import sdsm_pkg::*;
(
  input  wire logic                    clk,
  output sdsm_pkg::sdsm_bus_req_t      bus_req,
  input  wire logic [31:0]             rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial bus_req = '0;
  // ---------------------------------------------------------------
  // one-cycle strobes, changed only just after a rising edge
  // ---------------------------------------------------------------
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req <= '0;
  endtask : bus_write
  // read data stand only in the cycle after the strobe, so grab them there
  task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req <= '0;
    #1 d = rdata;
  endtask : bus_read
endmodule : sdsm_host

// ---- tb/sdsm_monitor_test.sv ----
// self-checking bench for the servo drive status monitor bank
module sdsm_monitor_test
  import sdsm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic           clk       = 1'b0;
  logic           reset_n   = 1'b0;
  logic           hw_en     = 1'b1;
  logic           trap      = 1'b0;
  logic [7:0]     cur_pct   = 8'h0;
  logic [15:0]    freq      = 16'h0;
  logic [15:0]    torque    = 16'h1234;
  logic [15:0]    nontorque = 16'h8765;
  logic [11:0]    hs_temp   = 12'h100;
  logic [11:0]    hs_trip   = 12'h320;
  logic [4:0]     model     = 5'h2;
  logic [3:0]     dip       = 4'h0;
  logic [3:0]     rot       = 4'h0;
  sdsm_feedback_t fb        = '0;
  sdsm_bus_req_t  bus_req;
  logic [31:0]    rdata;
  logic [31:0]    rd_val;
  logic           irq, pwr, halving, over_temp, cfg_err;
  int             n_fail      = 0;
  int             check_count = 0;
  always #2.5 clk = ~clk;
  sdsm_host u_host (.clk(clk), .bus_req(bus_req), .rdata(rdata));
  sdsm_monitor u_dut (.clk(clk), .reset_n(reset_n), .bus_req(bus_req), .rdata(rdata),
    .irq(irq), .hw_enable_pin(hw_en), .motor_power_enable(pwr), .pwm_halving_flag(halving),
    .heatsink_over_temp(over_temp), .config_error(cfg_err), .motor_current_pct(cur_pct),
    .commutation_freq_chz(freq), .torque_current(torque), .nontorque_current(nontorque),
    .heatsink_temp(hs_temp), .heatsink_trip_temp(hs_trip), .model_code(model),
    .feedback(fb), .dip_switch_pins(dip), .rotary_switch_pins(rot),
    .trapezoidal_commutation_flag(trap));
  // ---------------------------------------------------------------
  // shared helpers
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // synchronisers plus output register need a few edges to settle
  task automatic settle();
    repeat (6) @(posedge clk);
    #1;
  endtask : settle
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    u_host.bus_read(a, rd_val);
    check(what, rd_val, exp);
  endtask : rd_chk
  task automatic wrap_up();
    if (n_fail == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_power();
    rd_chk("ctrl reset", SDSM_OFF_CTRL, 32'h1);
    check("power at reset", 32'(pwr), 32'h1);
    u_host.bus_write(SDSM_OFF_CTRL, 32'h0);
    settle();
    check("power sw off", 32'(pwr), 32'h0);
    u_host.bus_write(SDSM_OFF_CTRL, 32'h1);
    @(posedge clk);
    hw_en <= 1'b0;
    settle();
    check("power hw off", 32'(pwr), 32'h0);
    @(posedge clk);
    hw_en <= 1'b1;
    settle();
    check("power both on", 32'(pwr), 32'h1);
  endtask : t_power
  task automatic t_pwm();
    logic [7:0]  c[7] = '{8'd53, 8'd54, 8'd40, 8'd40, 8'd54, 8'd31, 8'd54};
    logic [15:0] f[7] = '{16'd289, 16'd289, 16'd289, 16'd478, 16'd100, 16'd100, 16'd290};
    logic [31:0] e[7] = '{32'h0, 32'h1, 32'h1, 32'h0, 32'h1, 32'h0, 32'h0};
    for (int i = 0; i < 7; i++) begin
      @(posedge clk);
      cur_pct <= c[i];
      freq <= f[i];
      settle();
      check("halving flag", 32'(halving), e[i]);
    end
  endtask : t_pwm
  task automatic t_temp_irq();
    @(posedge clk);
    hs_temp <= 12'h320;
    settle();
    check("over temp", 32'(over_temp), 32'h1);
    check("irq masked", 32'(irq), 32'h0);
    rd_chk("temp word", SDSM_OFF_TEMP, 32'h0320_0320);
    u_host.bus_write(SDSM_OFF_IRQ_EN, 32'h1);
    settle();
    check("irq raised", 32'(irq), 32'h1);
    @(posedge clk);
    hs_temp <= 12'h31f;
    settle();
    check("temp below trip", 32'(over_temp), 32'h0);
    rd_chk("irq status", SDSM_OFF_IRQ_STAT, 32'h3);
    rd_chk("irq status again", SDSM_OFF_IRQ_STAT, 32'h3);
    u_host.bus_write(SDSM_OFF_IRQ_CLR, 32'hf);
    settle();
    check("irq cleared", 32'(irq), 32'h0);
    rd_chk("irq status clear", SDSM_OFF_IRQ_STAT, 32'h0);
  endtask : t_temp_irq
  task automatic t_ident();
    logic [4:0]  m[3] = '{5'd6, 5'd7, 5'd31};
    logic [31:0] e[3] = '{32'h0, 32'h1, 32'h1};
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      model <= m[i];
      settle();
      check("config error", 32'(cfg_err), e[i]);
      rd_chk("ident word", SDSM_OFF_IDENT, {23'h0, m[i], SDSM_HW_REV});
    end
    rd_chk("logicware", SDSM_OFF_LW_VER, {8'h0, SDSM_LW_VER});
  endtask : t_ident
  task automatic t_feedback();
    @(posedge clk);
    fb <= '{angle: 16'h0, angle_raw: 24'habcdef, turns: 12'h800, speed: 16'h8001,
            fb_fault: 3'b011};
    dip <= 4'ha;
    rot <= 4'h9;
    trap <= 1'b1;
    settle();
    rd_chk("angle", SDSM_OFF_ANGLE, 32'h00ab_cdef);
    rd_chk("turns", SDSM_OFF_TURNS, 32'hffff_f800);
    rd_chk("speed", SDSM_OFF_SPEED, 32'hffff_8001);
    rd_chk("switches", SDSM_OFF_SWITCHES, 32'h0000_039a);
    rd_chk("currents", SDSM_OFF_CURRENT, 32'h1234_8765);
    rd_chk("unmapped", 8'h3c, 32'h0);
    rd_chk("filtered idle", SDSM_OFF_FILT_SPD, 32'h0);
    u_host.bus_read(SDSM_OFF_STATUS, rd_val);
    check("six step flag", 32'(rd_val[5]), 32'h1);
  endtask : t_feedback
  initial begin
    #100us;
    n_fail++;
    wrap_up();
  end
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    settle();
    t_power();
    t_pwm();
    t_temp_irq();
    t_ident();
    t_feedback();
    wrap_up();
  end
endmodule : sdsm_monitor_test
